/* test_window_watchdog_timer.sv */
/* test_window_watchdog_timer: register-level tests of wwdt_top.
   Assumes short sim periods: 16 cycles min period, 40 initial. */
module test_window_watchdog_timer
    import wwdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] CFG = 16'h0210;
    localparam logic [15:0] SVC = 16'h0311;
    logic       clk;
    logic       srst;
    wwdt_mode_t mode;
    wwdt_req_t  req;
    logic [7:0] rdData;
    logic       rdValid;
    logic       wdResetReq;
    logic       windowOpen;
    logic       wd_disabled_flag;
    int         failures;
    int         checks;

    wwdt_host_model u_wwdt_host_model (.clk(clk), .rdData(rdData), .req(req));
    wwdt_top #(.PERIOD_MIN_CYCLES(16), .INIT_TO_CYCLES(40)) u_wwdt_top (.clk(clk),
        .srst(srst), .req(req), .mode(mode), .rdData(rdData), .rdValid(rdValid),
        .wdResetReq(wdResetReq), .windowOpen(windowOpen), .wd_disabled_flag(wd_disabled_flag));

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_wwdt_host_model.rd(a, d);
        cmp("read", exp, d);
    endtask
    task automatic wrchk(input logic [15:0] a, input logic [7:0] d, input logic exp);
        u_wwdt_host_model.wr(a, d);
        cmp("resetReq", {7'h0, exp}, {7'h0, wdResetReq});
    endtask
    // pulse must come after lo and before hi cycles
    task automatic expire(input int lo, input int hi);
        int i;
        @(negedge clk); // step past the pulse of the fault just checked
        for (i = 0; i < hi && wdResetReq !== 1'b1; i++) @(negedge clk);
        cmp("expiry", 8'h01, {7'h0, i > lo && i < hi});
    endtask
    task report_and_stop;
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard, far beyond the ~170 cycles of the tests
    initial
    begin
        repeat (3000) @(posedge clk);
        failures++;
        report_and_stop();
    end
    initial
    begin
        failures = 0;
        checks = 0;
        srst = 1'b1;
        mode = '{normalMode: 1'b1, lowPower: 1'b0, testDisable: 1'b0};
        repeat (2) @(negedge clk);
        srst = 1'b0;
        rdchk(CFG, 8'h40);
        wrchk(CFG, 8'hF9, 1'b0);
        rdchk(16'h0310, 8'h41);
        rdchk(16'h0410, 8'h00);
        wrchk(SVC, SVC_FIRST, 1'b0);
        rdchk(CFG, 8'h01);
        repeat (16) @(negedge clk);
        rdchk(CFG, 8'h41);
        wrchk(SVC, SVC_SECOND, 1'b0);
        rdchk(CFG, 8'h01);
        repeat (16) @(negedge clk);
        wrchk(SVC, SVC_FIRST, 1'b0);
        repeat (18) @(negedge clk);
        wrchk(SVC, SVC_FIRST, 1'b1);
        wrchk(SVC, SVC_SECOND, 1'b1);
        wrchk(SVC, SVC_FIRST, 1'b0);
        wrchk(SVC, SVC_FIRST, 1'b1);
        expire(34, 44);
        wrchk(SVC, SVC_FIRST, 1'b0);
        expire(26, 36);
        mode.testDisable = 1'b1;
        rdchk(CFG, 8'h81);
        wrchk(SVC, SVC_FIRST, 1'b0);
        mode.testDisable = 1'b0;
        rdchk(CFG, 8'h41);
        wrchk(SVC, SVC_FIRST, 1'b0);
        mode.lowPower = 1'b1;
        rdchk(CFG, 8'h81);
        mode.lowPower = 1'b0;
        rdchk(CFG, 8'h41);
        mode.normalMode = 1'b0;
        rdchk(CFG, 8'h81);
        report_and_stop();
    end
endmodule // test_window_watchdog_timer

/* wwdt_host_model.sv */
/* wwdt_host_model: host side of the register port.
   Assumes strobes launched on falling edges of the base clock. */
module wwdt_host_model
    import wwdt_pkg::*;
(
    input wire logic       clk,
    input wire logic [7:0] rdData,
    output wwdt_req_t      req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;

    // one-cycle write strobe; data inverted after release, not held
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk);
        req.wr = 1'b0;
        req.wdata = ~d;
    endtask

    // read data stands from the taking edge on; take it half a cycle later, at the next falling edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk);
        d = rdData;
        req.rd = 1'b0;
        req.addr = ~a;
    endtask
endmodule // wwdt_host_model

/* wwdt_monitor.sv */
/* wwdt_monitor: port assertions for wwdt_top.
   Assumes one base clock and the bind below. */
module wwdt_monitor
    import wwdt_pkg::*;
(
    input wire logic       clk,
    input wire logic       srst,
    input wire wwdt_req_t  req,
    input wire wwdt_mode_t mode,
    input wire logic [7:0] rdData,
    input wire logic       rdValid,
    input wire logic       wdResetReq,
    input wire logic       windowOpen,
    input wire logic       wd_disabled_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hit;
    logic cfgRd;
    logic svcRd;
    logic svcWr;

    // decode of both bases, upper byte 0x02 or 0x03
    assign hit   = req.addr[15:9] == 7'h01;
    assign cfgRd = req.rd && hit && req.addr[7:0] == OFS_CFG_STAT;
    assign svcRd = req.rd && hit && req.addr[7:0] == OFS_SERVICE;
    assign svcWr = req.wr && hit && req.addr[7:0] == OFS_SERVICE;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    property p_rdAns; req.rd |=> rdValid; endproperty
    a_rdAns: assert property (p_rdAns) else $error("read not answered");
    property p_noAns; !req.rd |=> !rdValid; endproperty
    a_noAns: assert property (p_noAns) else $error("spurious rdValid");
    property p_off;
        wd_disabled_flag == !(mode.normalMode && !mode.lowPower && !mode.testDisable);
    endproperty
    a_off: assert property (p_off) else $error("wd_disabled_flag wrong");
    property p_cfg; cfgRd |=> rdData[7:3] == {$past(wd_disabled_flag), $past(windowOpen), 3'h0}; endproperty
    a_cfg: assert property (p_cfg) else $error("status byte wrong");
    property p_svcRd; svcRd |=> rdData == 8'h00; endproperty
    a_svcRd: assert property (p_svcRd) else $error("service read not zero");
    property p_closed;
        svcWr && !windowOpen && !wd_disabled_flag && !$past(wd_disabled_flag) && !$past(srst) |=> wdResetReq;
    endproperty
    a_closed: assert property (p_closed) else $error("closed write kept");
    property p_pulse; wdResetReq |=> !wdResetReq; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse too long");
    property p_quiet; wd_disabled_flag && $past(wd_disabled_flag) |-> !wdResetReq && !windowOpen; endproperty
    a_quiet: assert property (p_quiet) else $error("active while off");
endmodule // wwdt_monitor

bind wwdt_top wwdt_monitor u_wwdt_monitor (.clk(clk), .srst(srst), .req(req), .mode(mode),
    .rdData(rdData), .rdValid(rdValid), .wdResetReq(wdResetReq),
    .windowOpen(windowOpen), .wd_disabled_flag(wd_disabled_flag));

/* wwdt_pkg.sv */
/*
 * wwdt_pkg: constants, register map and bus carrier types for the
 * window watchdog. Assumes a 125 MHz base clock and a die-to-die
 * register port whose strobes are synchronous to that clock.
 */
// Contract
// - The watchdog runs only in Normal mode, clocked from its own base clock.
// - The timeout field picks a window period of 10 ms doubled per code up to 1280 ms.
// - After reset release a plain watchdog with a fixed initial timeout runs with window open.
// - 0xAA before the initial timeout enters window mode; expiry or another value resets.
// - In window mode service writes are forbidden in the first half of the period.
// - The window-open bit reads one while the service window is open, else zero.
// - In window mode a period expiry or a wrong value forces a watchdog reset.
// - While the test disable is present the watchdog is off and the off bit is set.
// - On disable the service state returns to default; re-enable needs the initial sequence.
// - Service writes while disabled are ignored entirely.
// - In low power the watchdog is halted and the service state returns to default.
// - A register read in Stop mode shows the watchdog-off bit set.
// - Offsets decode against base 0x0200 blocking and 0x0300 non-blocking.
package wwdt_pkg;

    // bus address layout
    localparam int unsigned         ADDR_W        = 16;
    localparam logic [ADDR_W-1:0]   BASE_BLOCKING = 16'h0200;
    localparam logic [ADDR_W-1:0]   BASE_NONBLOCK = 16'h0300;
    localparam logic [7:0]          OFS_CFG_STAT  = 8'h10;
    localparam logic [7:0]          OFS_SERVICE   = 8'h11;

    // register fields
    localparam int unsigned         BIT_OFF       = 7;
    localparam int unsigned         BIT_OPEN      = 6;
    localparam int unsigned         SEL_W         = 3;
    localparam logic [SEL_W-1:0]    SEL_RESET     = 3'h0;
    localparam logic [7:0]          SVC_FIRST     = 8'hAA;
    localparam logic [7:0]          SVC_SECOND    = 8'h55;
    localparam logic [7:0]          READ_ZERO     = 8'h00;

    // timing
    localparam int unsigned         CLK_KHZ       = 125000;
    localparam int unsigned         PERIOD_MIN_MS = 10;
    localparam int unsigned         INIT_TO_MS    = 256;
    localparam int unsigned         PERIOD_MIN_CYC = PERIOD_MIN_MS * CLK_KHZ;
    localparam int unsigned         INIT_TO_CYC   = INIT_TO_MS * CLK_KHZ;
    localparam int unsigned         CNT_W         = 32;

    // register access request from the die-to-die port
    typedef struct packed {
        logic               wr;
        logic               rd;
        logic [ADDR_W-1:0]  addr;
        logic [7:0]         wdata;
    } wwdt_req_t;

    // operating conditions of the die
    typedef struct packed {
        logic               normalMode;
        logic               lowPower;
        logic               testDisable;
    } wwdt_mode_t;

endpackage

/* wwdt_top.sv */
/*
 * wwdt_top: window watchdog with its register pair.
 *
 * behaviour in brief:
 *  - off state: counter cleared, next service value 0xAA, window shut
 *  - initial phase: plain timeout of INIT_TO_CYCLES, window shown open,
 *    any timeout code may be written without touching that timeout
 *  - first 0xAA service write moves to window mode
 *  - window mode: period is PERIOD_MIN_CYCLES shifted by the timeout code;
 *    first half closed, second half open
 *  - accepted write in the open half restarts the period, flips expected value
 *  - early write, wrong value or expiry: one-cycle reset request,
 *    then a fresh initial phase
 *  - disable, low power or non-normal mode drop straight to off
 *
 * register map, low address byte, either base page:
 *  - config/status: off bit, open bit, three zero bits, timeout code
 *  - service: write only, reads as zero
 *
 * timing, in base clock cycles:
 *  - reset pulse one cycle after the faulty write or the last counted cycle
 *  - window opens at half the period, counted from the restart
 *  - read data stands for the cycle after the read strobe only
 *
 * usage notes:
 *  - service the initial phase with 0xAA well before its timeout
 *  - after that, alternate 0x55 and 0xAA, each inside the open half
 *  - poll the open bit rather than counting on host timers, since the
 *    base clock runs apart from the bus clock
 *  - changing the timeout code mid-window moves the open point at once,
 *    and a shorter code can expire the running period at once
 *
 * hazards and limits:
 *  - the reset request is a pulse; the device reset logic must catch it
 *  - the timeout code is kept through disable; only srst clears it
 *  - a stretched or held write strobe counts as one write per cycle
 *
 * assumes clk is the independent base clock, register strobes arrive
 * synchronous to it, and wdResetReq is turned into a device reset
 * outside this block.
 */
module wwdt_top
    import wwdt_pkg::*;
#(
    parameter int unsigned PERIOD_MIN_CYCLES = PERIOD_MIN_CYC,
    parameter int unsigned INIT_TO_CYCLES    = INIT_TO_CYC
)
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire wwdt_req_t  req,
    input  wire wwdt_mode_t mode,
    output logic [7:0]      rdData,
    output logic            rdValid,
    output logic            wdResetReq,
    output logic            windowOpen,
    output logic            wd_disabled_flag
);

    typedef enum logic [1:0] { WW_OFF, WW_INIT, WW_WINDOW } wwdt_state_t;

    wwdt_state_t        state_ff,   nxt_state;
    logic [CNT_W-1:0]   cnt_ff,     nxt_cnt;
    logic               expectAa_ff, nxt_expectAa;
    logic [SEL_W-1:0]   sel_ff,     nxt_sel;
    logic               rst_ff,     nxt_rst;
    logic [7:0]         rdData_ff,  nxt_rdData;
    logic               rdValid_ff, nxt_rdValid;

    logic               active;
    logic               hitBase;
    logic [7:0]         ofs;
    logic               cfgWr;
    logic               svcWr;
    logic [CNT_W-1:0]   period;
    logic [CNT_W-1:0]   halfPeriod;
    logic               svcValue;
    logic               winOpen;
    logic               initExpired;
    logic               periodExpired;
    logic [CNT_W-1:0]   periodTable [2**SEL_W];

    // running conditions: normal mode, not halted, not test-disabled
    assign active = mode.normalMode & ~mode.lowPower & ~mode.testDisable;
    assign wd_disabled_flag  = ~active;

    // address decode against either global window
    assign ofs     = req.addr[7:0];
    assign hitBase = (req.addr[ADDR_W-1:8] == BASE_BLOCKING[ADDR_W-1:8])
                   | (req.addr[ADDR_W-1:8] == BASE_NONBLOCK[ADDR_W-1:8]);
    assign cfgWr   = req.wr & hitBase & (ofs == OFS_CFG_STAT);
    assign svcWr   = req.wr & hitBase & (ofs == OFS_SERVICE) & active;

    // period doubles per code; shift keeps it one multiplier-free path
    genvar code;
    generate
        for (code = 0; code < 2**SEL_W; code++)
        begin : g_period
            // one period per timeout code, precomputed constants
            assign periodTable[code] = CNT_W'(PERIOD_MIN_CYCLES) << code;
        end
    endgenerate
    assign period     = periodTable[sel_ff];
    assign halfPeriod = period >> 1;
    assign svcValue   = expectAa_ff ? (req.wdata == SVC_FIRST)
                                    : (req.wdata == SVC_SECOND);

    // expiry points, on the last counted cycle of each phase
    assign initExpired   = (cnt_ff >= CNT_W'(INIT_TO_CYCLES - 1));
    assign periodExpired = (cnt_ff >= period - CNT_W'(1));

    // open in the initial phase, and in the second half of a window
    always_comb
    begin
        case (state_ff)
            WW_INIT:   winOpen = 1'b1;
            WW_WINDOW: winOpen = (cnt_ff >= halfPeriod);
            default:   winOpen = 1'b0;
        endcase
    end
    assign windowOpen = winOpen;

    // sequence overview, one row per move:
    //   off      -> initial  when the die is running again
    //   initial  -> window   on a 0xAA service write
    //   initial  -> initial  with a reset pulse on a wrong value or expiry
    //   window   -> window   on the expected value in the open half
    //   window   -> initial  with a reset pulse on an early write,
    //                        a wrong value or a period expiry
    //   any      -> off      when disabled, halted or out of normal mode
    // the counter runs every cycle outside off and is cleared on each move, so a
    // period always starts with the closed half; the expected value
    // starts at 0xAA after every reset, disable or pulse

    // watchdog sequence next state
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff + CNT_W'(1);
        nxt_expectAa = expectAa_ff;
        nxt_rst      = 1'b0;
        case (state_ff)
            WW_OFF:
            begin
                // service state held at default while stopped
                nxt_cnt      = '0;
                nxt_expectAa = 1'b1;
                if (active)
                begin
                    nxt_state = WW_INIT;
                end
            end
            WW_INIT:
            begin
                if (svcWr)
                begin
                    // first service write decides: window mode or fault
                    if (req.wdata == SVC_FIRST)
                    begin
                        nxt_state    = WW_WINDOW;
                        nxt_cnt      = '0;
                        nxt_expectAa = 1'b0;
                    end
                    else
                    begin
                        nxt_rst = 1'b1;
                        nxt_cnt = '0;
                    end
                end
                else if (initExpired)
                begin
                    // no 0xAA in time; counter restarts, phase kept
                    nxt_rst = 1'b1;
                    nxt_cnt = '0;
                end
            end
            WW_WINDOW:
            begin
                if (svcWr)
                begin
                    // only the expected value in the open half is a service
                    if (winOpen && svcValue)
                    begin
                        nxt_cnt      = '0;
                        nxt_expectAa = ~expectAa_ff;
                    end
                    else
                    begin
                        // early write or wrong value
                        nxt_rst      = 1'b1;
                        nxt_state    = WW_INIT;
                        nxt_cnt      = '0;
                        nxt_expectAa = 1'b1;
                    end
                end
                else if (periodExpired)
                begin
                    // whole period passed without service
                    nxt_rst      = 1'b1;
                    nxt_state    = WW_INIT;
                    nxt_cnt      = '0;
                    nxt_expectAa = 1'b1;
                end
            end
            default:
            begin
                nxt_state = WW_OFF;
                nxt_cnt   = '0;
            end
        endcase
        // disable or low power wins over everything above
        if (!active)
        begin
            nxt_state    = WW_OFF;
            nxt_cnt      = '0;
            nxt_expectAa = 1'b1;
            nxt_rst      = 1'b0;
        end
    end

    // sequence registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_ff    <= WW_OFF;
            cnt_ff      <= '0;
            expectAa_ff <= 1'b1;
            rst_ff      <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            expectAa_ff <= nxt_expectAa;
            rst_ff      <= nxt_rst;
        end
    end
    assign wdResetReq = rst_ff;

    // timeout field: writable any time, only the window phase uses it
    always_comb
    begin
        nxt_sel = sel_ff;
        if (cfgWr)
        begin
            nxt_sel = req.wdata[SEL_W-1:0];
        end
    end

    // read path: service register is write-only and reads zero
    // status bits come from live state, never from stored copies,
    // so a write to them has nothing to land in
    always_comb
    begin
        nxt_rdData  = READ_ZERO;
        nxt_rdValid = req.rd;
        if (req.rd && hitBase && (ofs == OFS_CFG_STAT))
        begin
            nxt_rdData[BIT_OFF]     = ~active;
            nxt_rdData[BIT_OPEN]    = winOpen;
            nxt_rdData[SEL_W-1:0]   = sel_ff;
        end
    end

    // timeout field register; survives disable on purpose
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sel_ff <= SEL_RESET;
        end
        else
        begin
            sel_ff <= nxt_sel;
        end
    end

    // read registers; data drops back to zero between reads
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdData_ff  <= READ_ZERO;
            rdValid_ff <= 1'b0;
        end
        else
        begin
            rdData_ff  <= nxt_rdData;
            rdValid_ff <= nxt_rdValid;
        end
    end
    assign rdData  = rdData_ff;
    assign rdValid = rdValid_ff;

endmodule // wwdt_top
